// [inc/aacr_pkg.sv]
// Constants and types shared by the audio amplifier control register block
package aacr_pkg;

    // ========================================================================
    // Register indices (byte address is four times the index)
    // ========================================================================
    localparam logic [7:0] AACR_IDX_SERIAL_INPUT_FORMAT = 8'h04;
    localparam logic [7:0] AACR_IDX_SYSTEM_CONTROL_TWO = 8'h05;
    localparam logic [7:0] AACR_IDX_CHANNEL_SOFT_MUTE = 8'h06;
    localparam logic [7:0] AACR_IDX_MASTER_VOLUME = 8'h07;
    localparam logic [7:0] AACR_IDX_CHANNEL_ONE_VOLUME = 8'h08;
    localparam logic [7:0] AACR_IDX_CHANNEL_TWO_VOLUME = 8'h09;
    localparam logic [7:0] AACR_IDX_CHANNEL_THREE_VOLUME = 8'h0A;
    localparam logic [7:0] AACR_IDX_VOLUME_RAMP_CONFIG = 8'h0E;
    localparam logic [7:0] AACR_IDX_RAMP_STATUS = 8'h0F;
    localparam logic [7:0] AACR_IDX_PWM_DUTY_LIMIT = 8'h10;

    // ========================================================================
    // Reset values
    // ========================================================================
    localparam logic [3:0] AACR_RST_FORMAT = 4'h5;
    localparam logic [7:0] AACR_RST_SYS_CTRL = 8'h40;
    localparam logic [2:0] AACR_RST_SOFT_MUTE = 3'h0;
    localparam logic [7:0] AACR_RST_MASTER_VOL = 8'hFF;
    localparam logic [7:0] AACR_RST_CHAN_VOL = 8'h30;
    localparam logic [1:0] AACR_RST_LINK = 2'h0;
    localparam logic [2:0] AACR_RST_SLEW = 3'h1;
    localparam logic [2:0] AACR_RST_DUTY_LIMIT = 3'h2;

    // ========================================================================
    // Field positions and codes
    // ========================================================================
    localparam int AACR_BIT_MIDZ = 7;
    localparam int AACR_BIT_SHUTDOWN = 6;
    localparam int AACR_BIT_THREE_LEVEL = 3;
    localparam int AACR_BIT_SINGLE_ENDED = 2;
    localparam int AACR_BIT_FAULT_PIN = 1;
    localparam int AACR_BIT_SUB_LINK = 6;
    localparam int AACR_BIT_CH3_LINK = 5;
    localparam logic [7:0] AACR_VOL_MUTE = 8'hFF;
    localparam logic [7:0] AACR_VOL_FLOOR = 8'hFE;
    localparam logic [7:0] AACR_VOL_UNITY = 8'h30;
    localparam logic [6:0] AACR_DUTY_FULL = 7'h7F;
    localparam int AACR_FRAC_BITS = 11;

    // ========================================================================
    // Step timing
    // ========================================================================
    localparam int AACR_CLK_PERIOD_PS = 5000;
    localparam int AACR_STEP_LOW_NS = 125000;
    localparam int AACR_STEP_441_NS = 90700;
    localparam int AACR_STEP_48_NS = 83300;
    localparam int AACR_STEP_LOW_CYC = AACR_STEP_LOW_NS * 1000 / AACR_CLK_PERIOD_PS;
    localparam int AACR_STEP_441_CYC = AACR_STEP_441_NS * 1000 / AACR_CLK_PERIOD_PS;
    localparam int AACR_STEP_48_CYC = AACR_STEP_48_NS * 1000 / AACR_CLK_PERIOD_PS;

    // Sample-rate family codes on the rate input
    localparam logic [1:0] AACR_RATE_LOW = 2'h0;
    localparam logic [1:0] AACR_RATE_441 = 2'h1;

    // ========================================================================
    // Types
    // ========================================================================
    // Framing of the serial audio input
    typedef enum logic [1:0] {
        AACR_FRAME_RIGHT = 2'h0,
        AACR_FRAME_STD = 2'h1,
        AACR_FRAME_LEFT = 2'h2
    } aacr_frame_t;

    // Decoded serial format
    typedef struct packed {
        aacr_frame_t frame;
        logic [1:0] word_len;
    } aacr_format_t;

    // Latched AHB address phase
    typedef struct packed {
        logic valid;
        logic write;
        logic mapped;
        logic [7:0] index;
    } aacr_ahb_req_t;

endpackage

// [hw/aacr_regs.sv]
// Register bank of the audio amplifier control block with volume ramping
//
// Operation
// - Decode nine serial formats, reset standard 24-bit
// - Shutdown bit high holds outputs hard muted
// - Bit selects AD or BD subchannel modulation
// - Bit selects 2.0 or 2.1 output arrangement
// - Bit turns address pin into fault output
// - Three soft mute bits force 50% duty
// - Volume code: 0.5 dB steps, all-ones mutes
// - Reset: master muted, channels at 0 dB
// - Step interval follows sample-rate family
// - Slew field sets ramp step count
// - Mute transitions use the same ramp
// - Subchannel follows channel one unless linked off
// - Channel three follows channel two unless linked off
// - Limit field caps PWM duty cycle
`timescale 1ns/1ps
module aacr_regs
    import aacr_pkg::*;
#(
    parameter int STEP_LOW_CYC = AACR_STEP_LOW_CYC,
    parameter int STEP_441_CYC = AACR_STEP_441_CYC,
    parameter int STEP_48_CYC = AACR_STEP_48_CYC
) (
    input wire logic CORE_CLK_IN,
    input wire logic RST_IN,
    // AHB-Lite slave
    input wire logic HSEL_IN,
    input wire logic [31:0] HADDR_IN,
    input wire logic [1:0] HTRANS_IN,
    input wire logic HWRITE_IN,
    input wire logic [2:0] HSIZE_IN,
    input wire logic [31:0] HWDATA_IN,
    input wire logic HREADY_IN,
    output logic [31:0] HRDATA_OUT,
    output logic HREADYOUT_OUT,
    output logic HRESP_OUT,
    // Sample-rate family from the clock detector
    input wire logic [1:0] RATE_FAMILY_IN,
    // Fault level from the protection logic, and address-select pin
    input wire logic FAULT_IN,
    input wire logic ADDR_SEL_IN,
    output logic ADDR_SEL_OUT,
    output logic ADDR_SEL_OE_OUT,
    output logic ADDR_SEL_LEVEL_OUT,
    // Control to the audio path
    output logic [1:0] FRAME_MODE_OUT,
    output logic [1:0] WORD_LEN_OUT,
    output logic SHUTDOWN_OUT,
    output logic MIDZ_RAMP_EN_OUT,
    output logic THREE_LEVEL_MODULATION_OUT,
    output logic SINGLE_ENDED_OUTPUT_OUT,
    output logic [2:0] HALF_DUTY_OUT,
    output logic [6:0] MAX_DUTY_OUT,
    output logic [31:0] GAIN_CODE_OUT,
    output logic [3:0] RAMP_BUSY_OUT
);

    // ========================================================================
    // Register storage
    // ========================================================================
    logic [3:0] format_code_q; // Serial format code
    logic [7:0] sys_ctrl_q; // Shutdown, modulation, arrangement, pin use
    logic [2:0] soft_mute_q; // One bit per channel
    logic [7:0] master_vol_q; // Master volume code
    logic [7:0] chan_vol_q [3]; // Channel one to three volume codes
    logic [1:0] link_q; // Subchannel link (1), channel three link (0)
    logic [2:0] slew_q; // Ramp step count code
    logic [2:0] duty_limit_q; // Modulation cap code
    aacr_format_t format_q; // Decoded format
    aacr_ahb_req_t req_q; // Pending data phase
    logic [31:0] rdata_q; // Read data for the data phase
    logic fault_q; // Registered fault level
    logic sel_level_q; // Registered address-select level

    // ========================================================================
    // Bus address phase decode
    // ========================================================================
    logic take_req; // Address phase accepted this edge
    logic [7:0] addr_index; // Word index of the address
    logic addr_mapped; // Index hits a register
    logic do_write; // Data phase write lands now

    assign take_req = HSEL_IN && HREADY_IN && HTRANS_IN[1];
    assign addr_index = HADDR_IN[9:2];
    assign do_write = req_q.valid && req_q.write && req_q.mapped;

    // Map check; misaligned or high addresses read as zero
    always_comb begin
        addr_mapped = 1'b0;
        if (HADDR_IN[31:10] == 22'h0 && HADDR_IN[1:0] == 2'h0) begin
            case (addr_index)
                AACR_IDX_SERIAL_INPUT_FORMAT, AACR_IDX_SYSTEM_CONTROL_TWO,
                AACR_IDX_CHANNEL_SOFT_MUTE, AACR_IDX_MASTER_VOLUME,
                AACR_IDX_CHANNEL_ONE_VOLUME, AACR_IDX_CHANNEL_TWO_VOLUME,
                AACR_IDX_CHANNEL_THREE_VOLUME, AACR_IDX_VOLUME_RAMP_CONFIG,
                AACR_IDX_RAMP_STATUS, AACR_IDX_PWM_DUTY_LIMIT: begin
                    addr_mapped = 1'b1;
                end
                default: begin
                    addr_mapped = 1'b0;
                end
            endcase
        end
    end

    // Address phase latch; every transfer finishes with no wait state
    always_ff @(posedge CORE_CLK_IN) begin
        if (RST_IN) begin
            req_q <= '0;
        end else if (HREADY_IN) begin
            req_q.valid <= take_req;
            req_q.write <= HWRITE_IN;
            req_q.mapped <= addr_mapped;
            req_q.index <= addr_index;
        end
    end

    // Slave never stalls and never errors
    always_ff @(posedge CORE_CLK_IN) begin
        if (RST_IN) begin
            HREADYOUT_OUT <= 1'b0;
            HRESP_OUT <= 1'b0;
        end else begin
            HREADYOUT_OUT <= 1'b1;
            HRESP_OUT <= 1'b0;
        end
    end

    // ========================================================================
    // Register writes
    // ========================================================================
    logic master_is_mute; // Gate for the linking bits
    assign master_is_mute = (master_vol_q == AACR_VOL_MUTE);

    // Control and volume registers
    always_ff @(posedge CORE_CLK_IN) begin
        if (RST_IN) begin
            format_code_q <= AACR_RST_FORMAT;
            sys_ctrl_q <= AACR_RST_SYS_CTRL;
            soft_mute_q <= AACR_RST_SOFT_MUTE;
            master_vol_q <= AACR_RST_MASTER_VOL;
            chan_vol_q[0] <= AACR_RST_CHAN_VOL;
            chan_vol_q[1] <= AACR_RST_CHAN_VOL;
            chan_vol_q[2] <= AACR_RST_CHAN_VOL;
            link_q <= AACR_RST_LINK;
            slew_q <= AACR_RST_SLEW;
            duty_limit_q <= AACR_RST_DUTY_LIMIT;
        end else if (do_write) begin
            case (req_q.index)
                AACR_IDX_SERIAL_INPUT_FORMAT: begin
                    format_code_q <= HWDATA_IN[3:0];
                end
                AACR_IDX_SYSTEM_CONTROL_TWO: begin
                    // Only the defined bits are kept
                    sys_ctrl_q <= HWDATA_IN[7:0] & 8'hCE;
                end
                AACR_IDX_CHANNEL_SOFT_MUTE: begin
                    soft_mute_q <= HWDATA_IN[2:0];
                end
                AACR_IDX_MASTER_VOLUME: begin
                    master_vol_q <= HWDATA_IN[7:0];
                end
                AACR_IDX_CHANNEL_ONE_VOLUME: begin
                    chan_vol_q[0] <= HWDATA_IN[7:0];
                end
                AACR_IDX_CHANNEL_TWO_VOLUME: begin
                    chan_vol_q[1] <= HWDATA_IN[7:0];
                end
                AACR_IDX_CHANNEL_THREE_VOLUME: begin
                    chan_vol_q[2] <= HWDATA_IN[7:0];
                end
                AACR_IDX_VOLUME_RAMP_CONFIG: begin
                    slew_q <= HWDATA_IN[2:0];
                    // Relinking mid-play would jump the gain, so it is refused
                    if (master_is_mute) begin
                        link_q <= {HWDATA_IN[AACR_BIT_SUB_LINK], HWDATA_IN[AACR_BIT_CH3_LINK]};
                    end
                end
                AACR_IDX_PWM_DUTY_LIMIT: begin
                    duty_limit_q <= HWDATA_IN[2:0];
                end
                default: begin
                end
            endcase
        end
    end

    // ========================================================================
    // Register reads
    // ========================================================================
    logic [7:0] rd_value; // Value for the index in the address phase
    logic [3:0] busy; // Ramp running per channel

    // Read mux; reserved bits read as zero
    always_comb begin
        rd_value = 8'h00;
        case (addr_index)
            AACR_IDX_SERIAL_INPUT_FORMAT: rd_value = {4'h0, format_code_q};
            AACR_IDX_SYSTEM_CONTROL_TWO: rd_value = sys_ctrl_q;
            AACR_IDX_CHANNEL_SOFT_MUTE: rd_value = {5'h00, soft_mute_q};
            AACR_IDX_MASTER_VOLUME: rd_value = master_vol_q;
            AACR_IDX_CHANNEL_ONE_VOLUME: rd_value = chan_vol_q[0];
            AACR_IDX_CHANNEL_TWO_VOLUME: rd_value = chan_vol_q[1];
            AACR_IDX_CHANNEL_THREE_VOLUME: rd_value = chan_vol_q[2];
            AACR_IDX_VOLUME_RAMP_CONFIG: rd_value = {1'b0, link_q, 2'h0, slew_q};
            AACR_IDX_RAMP_STATUS: rd_value = {4'h0, busy};
            AACR_IDX_PWM_DUTY_LIMIT: rd_value = {5'h00, duty_limit_q};
            default: rd_value = 8'h00;
        endcase
    end

    // Read data is captured at the address phase; a write in the same edge
    // to the same register, except ramp config and ramp status, is forwarded so software reads what it wrote
    always_ff @(posedge CORE_CLK_IN) begin
        if (RST_IN) begin
            rdata_q <= 32'h0000_0000;
        end else if (take_req && !HWRITE_IN) begin
            if (!addr_mapped) begin
                rdata_q <= 32'h0000_0000;
            end else if (do_write && req_q.index == addr_index &&
                         addr_index != AACR_IDX_RAMP_STATUS &&
                         addr_index != AACR_IDX_VOLUME_RAMP_CONFIG) begin
                rdata_q <= {24'h000000, HWDATA_IN[7:0] & rd_mask(addr_index)};
            end else begin
                rdata_q <= {24'h000000, rd_value};
            end
        end
    end
    assign HRDATA_OUT = rdata_q;

    // Width of the stored field for the forwarded registers
    function automatic logic [7:0] rd_mask(input logic [7:0] idx);
        case (idx)
            AACR_IDX_SERIAL_INPUT_FORMAT: rd_mask = 8'h0F;
            AACR_IDX_SYSTEM_CONTROL_TWO: rd_mask = 8'hCE;
            AACR_IDX_CHANNEL_SOFT_MUTE: rd_mask = 8'h07;
            AACR_IDX_PWM_DUTY_LIMIT: rd_mask = 8'h07;
            default: rd_mask = 8'hFF;
        endcase
    endfunction

    // ========================================================================
    // Serial format decode
    // ========================================================================
    // Reserved codes keep the last valid framing rather than guess one
    always_ff @(posedge CORE_CLK_IN) begin
        if (RST_IN) begin
            format_q <= '{frame: AACR_FRAME_STD, word_len: 2'h2};
        end else begin
            case (format_code_q)
                4'h0: format_q <= '{frame: AACR_FRAME_RIGHT, word_len: 2'h0};
                4'h1: format_q <= '{frame: AACR_FRAME_RIGHT, word_len: 2'h1};
                4'h2: format_q <= '{frame: AACR_FRAME_RIGHT, word_len: 2'h2};
                4'h3: format_q <= '{frame: AACR_FRAME_STD, word_len: 2'h0};
                4'h4: format_q <= '{frame: AACR_FRAME_STD, word_len: 2'h1};
                4'h5: format_q <= '{frame: AACR_FRAME_STD, word_len: 2'h2};
                4'h6: format_q <= '{frame: AACR_FRAME_LEFT, word_len: 2'h0};
                4'h7: format_q <= '{frame: AACR_FRAME_LEFT, word_len: 2'h1};
                4'h8: format_q <= '{frame: AACR_FRAME_LEFT, word_len: 2'h2};
                default: format_q <= format_q;
            endcase
        end
    end
    assign FRAME_MODE_OUT = format_q.frame;
    assign WORD_LEN_OUT = format_q.word_len;

    // ========================================================================
    // Control outputs
    // ========================================================================
    assign SHUTDOWN_OUT = sys_ctrl_q[AACR_BIT_SHUTDOWN];
    assign MIDZ_RAMP_EN_OUT = sys_ctrl_q[AACR_BIT_MIDZ];
    assign THREE_LEVEL_MODULATION_OUT = sys_ctrl_q[AACR_BIT_THREE_LEVEL];
    assign SINGLE_ENDED_OUTPUT_OUT = sys_ctrl_q[AACR_BIT_SINGLE_ENDED];
    assign ADDR_SEL_OE_OUT = sys_ctrl_q[AACR_BIT_FAULT_PIN];
    assign HALF_DUTY_OUT = soft_mute_q;

    // Duty cap in 1/128 units: code 0 gives 127/128, code 7 gives 120/128
    always_ff @(posedge CORE_CLK_IN) begin
        if (RST_IN) begin
            MAX_DUTY_OUT <= AACR_DUTY_FULL - {4'h0, AACR_RST_DUTY_LIMIT};
        end else begin
            MAX_DUTY_OUT <= AACR_DUTY_FULL - {4'h0, duty_limit_q};
        end
    end

    // Fault drive and address-select sampling share the pin
    always_ff @(posedge CORE_CLK_IN) begin
        if (RST_IN) begin
            fault_q <= 1'b0;
            sel_level_q <= 1'b0;
        end else begin
            fault_q <= FAULT_IN;
            // While driving, the pin no longer carries the address strap
            if (!sys_ctrl_q[AACR_BIT_FAULT_PIN]) begin
                sel_level_q <= ADDR_SEL_IN;
            end
        end
    end
    assign ADDR_SEL_OUT = fault_q;
    assign ADDR_SEL_LEVEL_OUT = sel_level_q;

    // ========================================================================
    // Volume step tick
    // ========================================================================
    logic [14:0] tick_cnt_q; // Cycles since the last step
    logic [14:0] tick_limit; // Interval for the present rate family
    logic step_tick; // One-cycle step enable

    // Interval chosen by the rate family reported by clock detection
    always_comb begin
        case (RATE_FAMILY_IN)
            AACR_RATE_LOW: tick_limit = 15'(STEP_LOW_CYC - 1);
            AACR_RATE_441: tick_limit = 15'(STEP_441_CYC - 1);
            default: tick_limit = 15'(STEP_48_CYC - 1);
        endcase
    end

    // Free-running divider; a rate change applies at once, to the interval already running
    always_ff @(posedge CORE_CLK_IN) begin
        if (RST_IN) begin
            tick_cnt_q <= 15'h0000;
        end else if (tick_cnt_q >= tick_limit) begin
            tick_cnt_q <= 15'h0000;
        end else begin
            tick_cnt_q <= tick_cnt_q + 15'h0001;
        end
    end
    assign step_tick = (tick_cnt_q >= tick_limit);

    // ========================================================================
    // Gain targets
    // ========================================================================
    // Master and channel gains add in dB; mute in either wins
    function automatic logic [7:0] combine(input logic [7:0] m, input logic [7:0] c);
        logic [9:0] sum;
        sum = {2'b00, m} + {2'b00, c} - {2'b00, AACR_VOL_UNITY};
        if (m == AACR_VOL_MUTE || c == AACR_VOL_MUTE) begin
            combine = AACR_VOL_MUTE;
        end else if ({2'b00, m} + {2'b00, c} < {2'b00, AACR_VOL_UNITY}) begin
            combine = 8'h00; // Capped at the top of the +24 dB range
        end else if (sum > {2'b00, AACR_VOL_FLOOR}) begin
            combine = AACR_VOL_FLOOR; // Clamped at the -103 dB floor
        end else begin
            combine = sum[7:0];
        end
    endfunction

    logic [7:0] target [4]; // Channel one, two, three, subchannel
    always_comb begin
        target[0] = combine(master_vol_q, chan_vol_q[0]);
        target[1] = combine(master_vol_q, chan_vol_q[1]);
        target[2] = combine(master_vol_q, link_q[0] ? chan_vol_q[2] : chan_vol_q[1]);
        target[3] = combine(master_vol_q, link_q[1] ? chan_vol_q[2] : chan_vol_q[0]);
    end

    // Per-step shift from the slew code; reserved codes behave as 1024 steps
    logic [1:0] step_shift;
    always_comb begin
        case (slew_q)
            3'h0: step_shift = 2'h2;
            3'h2: step_shift = 2'h0;
            3'h3: step_shift = 2'h3;
            default: step_shift = 2'h1;
        endcase
    end

    // ========================================================================
    // Gain ramps
    // ========================================================================
    // The gain is held with fractional bits so a large ramp spans the selected
    // number of steps and a small one fewer; mute is just the last code
    genvar ch;
    generate
        for (ch = 0; ch < 4; ch++) begin : g_ramp
            logic [18:0] acc_q; // Gain code with fraction
            logic [7:0] tgt_q; // Target of the running ramp
            logic [10:0] delta_q; // Fraction moved per step
            logic [7:0] diff; // Distance to a new target
            logic [18:0] goal; // Target scaled to the accumulator
            logic [10:0] delta_new; // Step for a new target

            assign goal = {target[ch], 11'h000};
            assign diff = (target[ch] > acc_q[18:11]) ? target[ch] - acc_q[18:11]
                        : acc_q[18:11] - target[ch];
            assign delta_new = ({3'h0, diff} << step_shift) | 11'h001;

            // Retarget at once, then move one step per tick
            always_ff @(posedge CORE_CLK_IN) begin
                if (RST_IN) begin
                    acc_q <= {AACR_VOL_MUTE, 11'h000};
                    tgt_q <= AACR_VOL_MUTE;
                    delta_q <= 11'h001;
                end else if (target[ch] != tgt_q) begin
                    tgt_q <= target[ch];
                    delta_q <= delta_new;
                end else if (step_tick && acc_q != goal) begin
                    if (acc_q < goal) begin
                        acc_q <= (goal - acc_q <= {8'h00, delta_q}) ? goal
                               : acc_q + {8'h00, delta_q};
                    end else begin
                        acc_q <= (acc_q - goal <= {8'h00, delta_q}) ? goal
                               : acc_q - {8'h00, delta_q};
                    end
                end
            end

            assign GAIN_CODE_OUT[ch*8 +: 8] = acc_q[18:11];
            assign busy[ch] = (acc_q != {tgt_q, 11'h000});
        end
    endgenerate

    // Busy flags registered for the outputs
    always_ff @(posedge CORE_CLK_IN) begin
        if (RST_IN) begin
            RAMP_BUSY_OUT <= 4'h0;
        end else begin
            RAMP_BUSY_OUT <= busy;
        end
    end
endmodule

// [tb/aacr_regs_sva.sv]
// Assertions on the ports of the amplifier control register block
`timescale 1ns/1ps
module aacr_regs_sva
    import aacr_pkg::*;
(
    input wire logic CORE_CLK_IN,
    input wire logic RST_IN,
    input wire logic HSEL_IN,
    input wire logic [31:0] HADDR_IN,
    input wire logic [1:0] HTRANS_IN,
    input wire logic HWRITE_IN,
    input wire logic [31:0] HWDATA_IN,
    input wire logic FAULT_IN,
    input wire logic ADDR_SEL_OUT,
    input wire logic ADDR_SEL_OE_OUT,
    input wire logic ADDR_SEL_LEVEL_OUT,
    input wire logic [1:0] FRAME_MODE_OUT,
    input wire logic [1:0] WORD_LEN_OUT,
    input wire logic SHUTDOWN_OUT,
    input wire logic [2:0] HALF_DUTY_OUT,
    input wire logic [6:0] MAX_DUTY_OUT,
    input wire logic [31:0] GAIN_CODE_OUT
);
    // ====
    // One clock domain, so clocking and reset are given once
    default clocking @(posedge CORE_CLK_IN); endclocking
    default disable iff (RST_IN);
    // Address phase of a write to one byte address
    sequence wr_at(a);
        HSEL_IN && HTRANS_IN[1] && HWRITE_IN && HADDR_IN == a;
    endsequence
    chk_sys_bits: assert property (wr_at(32'h14) |-> ##2
        {SHUTDOWN_OUT, ADDR_SEL_OE_OUT} == $past({HWDATA_IN[6], HWDATA_IN[1]})) else $error("sys");
    chk_half_duty: assert property (wr_at(32'h18) |-> ##2
        HALF_DUTY_OUT == $past(HWDATA_IN[2:0])) else $error("soft mute");
    chk_duty_cap: assert property (wr_at(32'h40) |-> ##3
        MAX_DUTY_OUT == 7'h7F - $past(HWDATA_IN[2:0], 2)) else $error("duty cap");
    chk_duty_range: assert property (MAX_DUTY_OUT >= 7'h78)
        else $error("duty range");
    chk_frame_legal: assert property (FRAME_MODE_OUT != 2'h3 && WORD_LEN_OUT != 2'h3)
        else $error("format");
    chk_fault_copy: assert property (ADDR_SEL_OE_OUT && !$past(RST_IN) |->
        ADDR_SEL_OUT == $past(FAULT_IN)) else $error("fault pin");
    chk_level_hold: assert property (ADDR_SEL_OE_OUT && $past(ADDR_SEL_OE_OUT) |->
        $stable(ADDR_SEL_LEVEL_OUT)) else $error("pin level");
    chk_gain_step: assert property ((GAIN_CODE_OUT[7:0] - $past(GAIN_CODE_OUT[7:0]))
        inside {8'h00, 8'h01, 8'hFF}) else $error("gain step");
endmodule

// [tb/testbench.sv]
// Self-checking bench for the amplifier control register block
`timescale 1ns/1ps
module testbench;
    logic clk, rst, hsel, hwrite, fault, asel, rd_dp, hrdy, shut;
    logic [1:0] htrans, frame, wlen, rate;
    logic [31:0] haddr, hwdata, hrdata, gain, v;
    logic [6:0] maxd;
    logic [3:0] busy;
    int num_errors = 0, check_count = 0, cyc;
    logic [63:0] exp_q[$]; // Address and expected data of each read
    localparam logic [31:0] ADR [10] = '{32'h10, 32'h14, 32'h18, 32'h1C, 32'h20, 32'h24, 32'h28,
        32'h38, 32'h40, 32'h30};
    localparam logic [7:0] RSTV [10] = '{8'h05, 8'h40, 0, 8'hFF, 8'h30, 8'h30, 8'h30, 1, 2, 0};
    localparam logic [7:0] MSK [10] = '{8'h0F, 8'hCE, 7, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h67, 7, 0};
    localparam logic [7:0] FRC [10] = '{0, 8'h02, 0, 8'hFF, 0, 0, 0, 8'h60, 0, 0};
    // Short step intervals (4, 3 and 2 cycles) keep ramps short
    aacr_regs #(.STEP_LOW_CYC(4), .STEP_441_CYC(3), .STEP_48_CYC(2)) i_aacr_regs (
        .CORE_CLK_IN(clk), .RST_IN(rst), .HSEL_IN(hsel), .HADDR_IN(haddr), .HTRANS_IN(htrans),
        .HWRITE_IN(hwrite), .HSIZE_IN(3'h2), .HWDATA_IN(hwdata), .HREADY_IN(hrdy),
        .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hrdy), .HRESP_OUT(), .RATE_FAMILY_IN(rate),
        .FAULT_IN(fault), .ADDR_SEL_IN(asel), .ADDR_SEL_OUT(), .ADDR_SEL_OE_OUT(),
        .ADDR_SEL_LEVEL_OUT(), .FRAME_MODE_OUT(frame), .WORD_LEN_OUT(wlen), .SHUTDOWN_OUT(shut),
        .MIDZ_RAMP_EN_OUT(), .THREE_LEVEL_MODULATION_OUT(), .SINGLE_ENDED_OUTPUT_OUT(),
        .HALF_DUTY_OUT(), .MAX_DUTY_OUT(maxd), .GAIN_CODE_OUT(gain), .RAMP_BUSY_OUT(busy));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // ====
    // Compare and count
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            num_errors++;
            $display("mismatch %s exp %h got %h", n, e, g);
        end
    endtask
    // One single AHB transfer, held until hready is seen high
    task xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge clk); while (hrdy !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        rd_dp <= !w;
        do @(posedge clk); while (hrdy !== 1'b1);
        rd_dp <= 1'b0;
    endtask
    task rd(input logic [31:0] a, input logic [31:0] e);
        exp_q.push_back({a, e});
        xfer(1'b0, a, 32'h0);
    endtask
    // Ramp to a target; n is the expected length in cycles, zero skips it
    task ramp(input logic [31:0] a, input logic [31:0] d, input int n, input logic [1:0] r);
        rate <= r;
        xfer(1'b1, a, d);
        cyc = 0;
        do begin
            @(posedge clk);
            cyc++;
        end while ((busy[0] !== 1'b0 || cyc < 4) && cyc < 9000);
        chk("ramp gain", d, gain[7:0]);
        if (n > 0) chk("ramp length", 1, cyc inside {[n - 4:n + 4]});
    endtask
    task end_sim();
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // Read monitor: takes the oldest note when read data is sampled
    always @(posedge clk) begin
        if (rd_dp && hrdy) begin
            chk($sformatf("reg %h", exp_q[0][63:32]), exp_q[0][31:0], hrdata);
            void'(exp_q.pop_front());
        end
    end
    // Pin levels wander randomly so the fault output path is exercised
    always @(posedge clk) begin
        fault <= 1'($urandom);
        asel <= 1'($urandom);
    end
    initial begin
        repeat (40000) @(posedge clk);
        num_errors++;
        end_sim();
    end
    initial begin
        void'($urandom(32'h3EA3A281));
        {rst, hsel, htrans, haddr, hwrite, hwdata, rd_dp, fault, asel, rate} = {2'h3, 70'h0, 2'h2};
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk("reset outs", 32'h00000B7D, {shut, frame, wlen, maxd});
        chk("reset gain", 32'hFFFFFFFF, gain);
        for (int i = 0; i < 10; i++) rd(ADR[i], RSTV[i]);
        $display("test reset values done");
        for (int i = 0; i < 10; i++) begin
            v = ($urandom & MSK[i]) | FRC[i];
            if (i == 0) v = $urandom_range(8);
            xfer(1'b1, ADR[i], v);
            rd(ADR[i], v);
        end
        $display("test write readback done");
        for (int c = 0; c < 10; c++) begin
            xfer(1'b1, 32'h10, (c < 9) ? c : 15);
            xfer(1'b1, 32'h40, c & 7);
            repeat (2) @(posedge clk);
            chk("format", ((c < 9) ? c / 3 * 4 + c % 3 : 10), {frame, wlen});
            chk("duty", 127 - (c & 7), maxd);
        end
        $display("test decode done");
        xfer(1'b1, 32'h1C, 32'h30);
        xfer(1'b1, 32'h38, 32'h03);
        rd(32'h38, 32'h63);
        ramp(32'h20, 32'h40, 0, 2'h2);
        ramp(32'h20, 32'h50, 768, 2'h1);
        ramp(32'h1C, 32'hFF, 1024, 2'h0);
        $display("test ramp done");
        end_sim();
    end
endmodule
bind aacr_regs aacr_regs_sva i_aacr_regs_sva (.*);
